/* auxsq_pkg.sv */
// Constants and types for the auxiliary output sequencing block
package auxsq_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OUT_ONE_DELAYS_ADDR = 8'h10;
    localparam logic [7:0] OUT_TWO_DELAYS_ADDR = 8'h11;
    localparam logic [7:0] OUT_CONTROL_ADDR = 8'h12;
    localparam logic [7:0] DEV_CONFIG_ADDR = 8'h13;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OUT_ONE_DELAYS_RST = 8'h00;
    localparam logic [7:0] OUT_TWO_DELAYS_RST = 8'h00;
    localparam logic [7:0] OUT_CONTROL_RST = 8'h00;
    localparam logic [7:0] DEV_CONFIG_RST = 8'h00;

    // Writable bits of the control register, reserved bits 7 and 3 clear
    localparam logic [7:0] OUT_CONTROL_WMASK = 8'h77;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FALL_CODE_LSB = 4;
    localparam int RISE_CODE_LSB = 0;
    localparam int OUT_ONE_LEVEL_BIT = 0;
    localparam int OUT_ONE_PIN_GATING_BIT = 1;
    localparam int OUT_ONE_DRIVE_TYPE_BIT = 2;
    localparam int OUT_TWO_LEVEL_BIT = 4;
    localparam int OUT_TWO_PIN_GATING_BIT = 5;
    localparam int OUT_TWO_DRIVE_TYPE_BIT = 6;
    localparam int RISE_RANGE_BIT = 6;
    localparam int FALL_RANGE_BIT = 5;
    localparam int SHARED_PIN_FUNCTION_BIT = 4;
    localparam int SHARED_PIN_PULLDOWN_BIT = 3;
    localparam int CONTROL_PIN_PULLDOWN_BIT = 2;
    localparam int DIE_HEAT_WARNING_BIT = 1;
    localparam int CLOCK_SPREADING_BIT = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int HALF_MS_PS = 500000000;
    localparam int HALF_MS_CYCLES = HALF_MS_PS / CLK_PERIOD_PS;
    localparam int STEP_CNT_W = 5;

    typedef enum logic [3:0] {
        SEQ_LOW = 4'b0001,
        SEQ_WAIT_RISE = 4'b0010,
        SEQ_HIGH = 4'b0100,
        SEQ_WAIT_FALL = 4'b1000
    } auxsq_state_t;

    // Delay in half-ms ticks: code, doubled in the extended range
    function automatic logic [STEP_CNT_W-1:0] half_ms_steps(
        input logic [3:0] code,
        input logic wide
    );
        half_ms_steps = wide ? {code, 1'b0} : {1'b0, code};
    endfunction : half_ms_steps

endpackage : auxsq_pkg

/* auxsq_tick.sv */
// Half-millisecond tick divider with restart
`timescale 1ns/1ns
module auxsq_tick #(
    parameter int DIV_CYCLES = auxsq_pkg::HALF_MS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic restart,
    output logic tick
);

    logic [23:0] div_reg;

    // Restart aligns the step grid to the enable edge
    always_ff @(posedge sys_clk) begin
        if (rst || restart || tick) begin
            div_reg <= 24'h000000;
        end else begin
            div_reg <= div_reg + 24'h000001;
        end
    end

    assign tick = (div_reg == 24'(DIV_CYCLES - 1));

endmodule : auxsq_tick

/* auxsq_seq.sv */
// Enable-edge sequencer: delayed rise and fall of one output
`timescale 1ns/1ns
module auxsq_seq (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable_pin,
    input wire logic tick,
    input wire logic [3:0] rise_code,
    input wire logic [3:0] fall_code,
    input wire logic rise_wide,
    input wire logic fall_wide,
    output logic edge_seen,
    output logic seq_out
);

    auxsq_pkg::auxsq_state_t state_reg;
    logic en_prev_reg;
    logic [auxsq_pkg::STEP_CNT_W-1:0] cnt_reg;
    logic [auxsq_pkg::STEP_CNT_W-1:0] rise_steps;
    logic [auxsq_pkg::STEP_CNT_W-1:0] fall_steps;
    logic rise_edge;
    logic fall_edge;

    assign rise_edge = enable_pin & ~en_prev_reg;
    assign fall_edge = ~enable_pin & en_prev_reg;
    assign edge_seen = rise_edge | fall_edge;
    assign rise_steps = auxsq_pkg::half_ms_steps(rise_code, rise_wide);
    assign fall_steps = auxsq_pkg::half_ms_steps(fall_code, fall_wide);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_prev_reg <= 1'b0;
        end else begin
            en_prev_reg <= enable_pin;
        end
    end

    // Codes are sampled at the edge; later writes do not stretch a wait
    // Edge finding the output already there skips the wait: no glitch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= auxsq_pkg::SEQ_LOW;
            cnt_reg <= '0;
        end else if (rise_edge) begin
            cnt_reg <= rise_steps;
            state_reg <= (rise_steps == '0 || seq_out) ? auxsq_pkg::SEQ_HIGH
                                            : auxsq_pkg::SEQ_WAIT_RISE;
        end else if (fall_edge) begin
            cnt_reg <= fall_steps;
            state_reg <= (fall_steps == '0 || !seq_out) ? auxsq_pkg::SEQ_LOW
                                            : auxsq_pkg::SEQ_WAIT_FALL;
        end else begin
            unique case (state_reg)
                auxsq_pkg::SEQ_WAIT_RISE: begin
                    if (tick) begin
                        cnt_reg <= cnt_reg - 5'h01;
                        if (cnt_reg == 5'h01) begin
                            state_reg <= auxsq_pkg::SEQ_HIGH;
                        end
                    end
                end
                auxsq_pkg::SEQ_WAIT_FALL: begin
                    if (tick) begin
                        cnt_reg <= cnt_reg - 5'h01;
                        if (cnt_reg == 5'h01) begin
                            state_reg <= auxsq_pkg::SEQ_LOW;
                        end
                    end
                end
                auxsq_pkg::SEQ_LOW: begin
                end
                auxsq_pkg::SEQ_HIGH: begin
                end
            endcase
        end
    end

    // Output stays high through the fall wait
    assign seq_out = (state_reg == auxsq_pkg::SEQ_HIGH)
                  || (state_reg == auxsq_pkg::SEQ_WAIT_FALL);

endmodule : auxsq_seq

/* auxsq_top.sv */
// Auxiliary output sequencing, drive control and device configuration
`timescale 1ns/1ns

// What this block does
// - Output one falls after enable falls, delayed
// - Output one rises after enable rises, delayed
// - Output two fall delay from enable fall
// - Output two rise delay from enable rise
// - Rise range bit: 0.5 ms or 1 ms steps
// - Fall range bit: 0.5 ms or 1 ms steps
// - Output one gating: level only, or with pin
// - Output two gating: level only, or with pin
// - Output one level bit sets driven level
// - Output two level applies in output function
// - Output one push-pull or open-drain drive
// - Output two push-pull or open-drain drive
// - Shared pin: second output or clock input
// - Shared pin pull-down enable, both functions
// - Enable pin pull-down enable
// - Heat warning threshold 125 or 137 degrees
// - Clock spreading enable bit
module auxsq_top #(
    parameter int HALF_MS_CYCLES = auxsq_pkg::HALF_MS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic enable_pin,
    output logic aux_output_one_o,
    output logic aux_output_one_oe,
    input wire logic external_clock_input_pin_i,
    output logic aux_output_two_o,
    output logic aux_output_two_oe,
    output logic external_clock,
    output logic external_clock_selected,
    output logic shared_pin_pulldown,
    output logic control_pin_pulldown,
    output logic die_heat_warning_threshold,
    output logic clock_spreading_on
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] aux_out_one_delays_reg;
    logic [7:0] aux_out_two_delays_reg;
    logic [7:0] aux_out_control_reg;
    logic [7:0] device_configuration_reg;
    logic [7:0] reg_rd_data_next;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_out_one_delays_reg <= auxsq_pkg::OUT_ONE_DELAYS_RST;
        end else if (reg_wr_en
                     && reg_addr == auxsq_pkg::OUT_ONE_DELAYS_ADDR) begin
            aux_out_one_delays_reg <= reg_wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_out_two_delays_reg <= auxsq_pkg::OUT_TWO_DELAYS_RST;
        end else if (reg_wr_en
                     && reg_addr == auxsq_pkg::OUT_TWO_DELAYS_ADDR) begin
            aux_out_two_delays_reg <= reg_wr_data;
        end
    end

    // Reserved bits never store anything
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_out_control_reg <= auxsq_pkg::OUT_CONTROL_RST;
        end else if (reg_wr_en
                     && reg_addr == auxsq_pkg::OUT_CONTROL_ADDR) begin
            aux_out_control_reg <= reg_wr_data
                                 & auxsq_pkg::OUT_CONTROL_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            device_configuration_reg <= auxsq_pkg::DEV_CONFIG_RST;
        end else if (reg_wr_en
                     && reg_addr == auxsq_pkg::DEV_CONFIG_ADDR) begin
            device_configuration_reg <= reg_wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        unique case (reg_addr)
            auxsq_pkg::OUT_ONE_DELAYS_ADDR: begin
                reg_rd_data_next = aux_out_one_delays_reg;
            end
            auxsq_pkg::OUT_TWO_DELAYS_ADDR: begin
                reg_rd_data_next = aux_out_two_delays_reg;
            end
            auxsq_pkg::OUT_CONTROL_ADDR: begin
                reg_rd_data_next = aux_out_control_reg
                                 & auxsq_pkg::OUT_CONTROL_WMASK;
            end
            auxsq_pkg::DEV_CONFIG_ADDR: begin
                reg_rd_data_next = device_configuration_reg;
            end
            default: begin
                reg_rd_data_next = 8'h00;
            end
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rd_data <= reg_rd_data_next;
        end
    end

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    logic rise_wide;
    logic fall_wide;
    logic out_one_level;
    logic out_one_pin_gating;
    logic out_one_drive_type;
    logic out_two_level;
    logic out_two_pin_gating;
    logic out_two_drive_type;
    logic shared_pin_function;

    assign rise_wide =
        device_configuration_reg[auxsq_pkg::RISE_RANGE_BIT];
    assign fall_wide =
        device_configuration_reg[auxsq_pkg::FALL_RANGE_BIT];
    assign shared_pin_function =
        device_configuration_reg[auxsq_pkg::SHARED_PIN_FUNCTION_BIT];
    assign out_one_level =
        aux_out_control_reg[auxsq_pkg::OUT_ONE_LEVEL_BIT];
    assign out_one_pin_gating =
        aux_out_control_reg[auxsq_pkg::OUT_ONE_PIN_GATING_BIT];
    assign out_one_drive_type =
        aux_out_control_reg[auxsq_pkg::OUT_ONE_DRIVE_TYPE_BIT];
    assign out_two_level =
        aux_out_control_reg[auxsq_pkg::OUT_TWO_LEVEL_BIT];
    assign out_two_pin_gating =
        aux_out_control_reg[auxsq_pkg::OUT_TWO_PIN_GATING_BIT];
    assign out_two_drive_type =
        aux_out_control_reg[auxsq_pkg::OUT_TWO_DRIVE_TYPE_BIT];

    // ------------------------------------------------------------------
    // Enable sequencers
    // ------------------------------------------------------------------
    logic one_tick;
    logic one_restart;
    logic one_seq;
    logic two_tick;
    logic two_restart;
    logic two_seq;

    // One divider per output so each step grid starts at its own edge
    auxsq_tick #(
        .DIV_CYCLES(HALF_MS_CYCLES)
    ) u_one_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(one_restart),
        .tick(one_tick)
    );

    auxsq_seq u_one_seq (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable_pin(enable_pin),
        .tick(one_tick),
        .rise_code(aux_out_one_delays_reg[
            auxsq_pkg::RISE_CODE_LSB +: 4]),
        .fall_code(aux_out_one_delays_reg[
            auxsq_pkg::FALL_CODE_LSB +: 4]),
        .rise_wide(rise_wide),
        .fall_wide(fall_wide),
        .edge_seen(one_restart),
        .seq_out(one_seq)
    );

    auxsq_tick #(
        .DIV_CYCLES(HALF_MS_CYCLES)
    ) u_two_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(two_restart),
        .tick(two_tick)
    );

    auxsq_seq u_two_seq (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable_pin(enable_pin),
        .tick(two_tick),
        .rise_code(aux_out_two_delays_reg[
            auxsq_pkg::RISE_CODE_LSB +: 4]),
        .fall_code(aux_out_two_delays_reg[
            auxsq_pkg::FALL_CODE_LSB +: 4]),
        .rise_wide(rise_wide),
        .fall_wide(fall_wide),
        .edge_seen(two_restart),
        .seq_out(two_seq)
    );

    // ------------------------------------------------------------------
    // Output levels
    // ------------------------------------------------------------------
    logic one_level_next;
    logic two_level_next;

    always_comb begin
        if (out_one_pin_gating) begin
            one_level_next = out_one_level & one_seq;
        end else begin
            one_level_next = out_one_level;
        end
    end

    always_comb begin
        if (out_two_pin_gating) begin
            two_level_next = out_two_level & two_seq;
        end else begin
            two_level_next = out_two_level;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Open drain only ever pulls low; high is left to the external pull-up
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_output_one_o <= 1'b0;
            aux_output_one_oe <= 1'b0;
        end else if (out_one_drive_type) begin
            aux_output_one_o <= 1'b0;
            aux_output_one_oe <= ~one_level_next;
        end else begin
            aux_output_one_o <= one_level_next;
            aux_output_one_oe <= 1'b1;
        end
    end

    // Driver released whenever the shared pin is a clock input
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_output_two_o <= 1'b0;
            aux_output_two_oe <= 1'b0;
        end else if (shared_pin_function) begin
            aux_output_two_o <= 1'b0;
            aux_output_two_oe <= 1'b0;
        end else if (out_two_drive_type) begin
            aux_output_two_o <= 1'b0;
            aux_output_two_oe <= ~two_level_next;
        end else begin
            aux_output_two_o <= two_level_next;
            aux_output_two_oe <= 1'b1;
        end
    end

    // Clock path forced low while the pin serves as an output
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            external_clock <= 1'b0;
            external_clock_selected <= 1'b0;
        end else begin
            external_clock <= shared_pin_function
                            & external_clock_input_pin_i;
            external_clock_selected <= shared_pin_function;
        end
    end

    // ------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shared_pin_pulldown <= 1'b0;
            control_pin_pulldown <= 1'b0;
            die_heat_warning_threshold <= 1'b0;
            clock_spreading_on <= 1'b0;
        end else begin
            shared_pin_pulldown <= device_configuration_reg[
                auxsq_pkg::SHARED_PIN_PULLDOWN_BIT];
            control_pin_pulldown <= device_configuration_reg[
                auxsq_pkg::CONTROL_PIN_PULLDOWN_BIT];
            die_heat_warning_threshold <= device_configuration_reg[
                auxsq_pkg::DIE_HEAT_WARNING_BIT];
            clock_spreading_on <= device_configuration_reg[
                auxsq_pkg::CLOCK_SPREADING_BIT];
        end
    end

endmodule : auxsq_top

/* auxsq_checker.sv */
// Assertion checker for the auxiliary output block
`timescale 1ns/1ns
module auxsq_checker #(
    parameter int HALF_MS_CYCLES = auxsq_pkg::HALF_MS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic enable_pin,
    input wire logic aux_output_one_o,
    input wire logic aux_output_one_oe,
    input wire logic external_clock_input_pin_i,
    input wire logic aux_output_two_o,
    input wire logic aux_output_two_oe,
    input wire logic external_clock,
    input wire logic external_clock_selected,
    input wire logic shared_pin_pulldown,
    input wire logic control_pin_pulldown,
    input wire logic die_heat_warning_threshold,
    input wire logic clock_spreading_on
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [4:0] cfg_pins;
    assign cfg_pins = {external_clock_selected, shared_pin_pulldown,
        control_pin_pulldown, die_heat_warning_threshold, clock_spreading_on};
    sequence ctrl_wr_s;
        reg_wr_en && reg_addr == 8'h12;
    endsequence
    sequence ctrl_rd_s;
        reg_rd_en && !reg_wr_en && reg_addr == 8'h12;
    endsequence
    // Two cycles in clock mode so both registered paths have settled
    sequence clk_mode_s;
        external_clock_selected [*2];
    endsequence
    rst_quiet_a: assert property (disable iff (1'b0) rst |=>
        !aux_output_one_oe && !aux_output_two_oe && reg_rd_data == 8'h00)
        else $error("outputs not quiet after reset");
    ctrl_rsvd_a: assert property (
        reg_rd_en && reg_addr == 8'h12 |=> !reg_rd_data[7] && !reg_rd_data[3])
        else $error("control reserved bit reads one");
    unmapped_read_a: assert property (reg_rd_en &&
        (reg_addr < 8'h10 || reg_addr > 8'h13) |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!reg_rd_en |=> $stable(reg_rd_data))
        else $error("read data moved without read");
    cfg_outputs_a: assert property (
        reg_wr_en && reg_addr == 8'h13 |=> ##1
        cfg_pins == $past(reg_wr_data[4:0], 2))
        else $error("config outputs differ from written value");
    ctrl_readback_a: assert property (
        ctrl_wr_s ##1 (!reg_wr_en) [*2] ##1 ctrl_rd_s |=>
        reg_rd_data == ($past(reg_wr_data, 4) & 8'h77))
        else $error("control readback wrong");
    two_released_a: assert property (
        clk_mode_s |-> !aux_output_two_oe)
        else $error("shared pin driven in clock mode");
    clock_pass_a: assert property (
        clk_mode_s |-> external_clock == $past(external_clock_input_pin_i))
        else $error("clock input not passed through");
    clock_idle_a: assert property (
        !external_clock_selected [*2] |-> !external_clock)
        else $error("clock output active in output mode");
endmodule : auxsq_checker

bind auxsq_top auxsq_checker #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .enable_pin(enable_pin),
    .aux_output_one_o(aux_output_one_o),
    .aux_output_one_oe(aux_output_one_oe),
    .external_clock_input_pin_i(external_clock_input_pin_i),
    .aux_output_two_o(aux_output_two_o),
    .aux_output_two_oe(aux_output_two_oe),
    .external_clock(external_clock),
    .external_clock_selected(external_clock_selected),
    .shared_pin_pulldown(shared_pin_pulldown),
    .control_pin_pulldown(control_pin_pulldown),
    .die_heat_warning_threshold(die_heat_warning_threshold),
    .clock_spreading_on(clock_spreading_on));

/* auxsq_pin_model.sv */
// Board-side model of the two output pins and the clock source
`timescale 1ns/1ns
module auxsq_pin_model (
    input wire logic one_o,
    input wire logic one_oe,
    input wire logic two_o,
    input wire logic two_oe,
    input wire logic pd_on,
    input wire logic src_on,
    input wire logic src_lvl,
    output logic one_pin,
    output logic two_pin
);
    // ------------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------------
    // Released line floats up through the board resistor
    assign one_pin = one_oe ? one_o : 1'b1;
    // Pull-down wins over the weak board resistor when released
    assign two_pin = two_oe ? two_o : src_on ? src_lvl : !pd_on;
endmodule : auxsq_pin_model

/* auxsq_bench.sv */
// Self-checking bench for the auxiliary output block
`timescale 1ns/1ns
module auxsq_bench;
    localparam int HALF = 10;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] reg_rd_data;
    logic enable_pin = 1'b0;
    logic src_on = 1'b0;
    logic src_lvl = 1'b0;
    logic one_o, one_oe, two_o, two_oe, one_pin, two_pin;
    logic ext_clk, ext_sel, sh_pd, ctl_pd, heat, spread;
    logic [7:0] cfg_pins;
    int n_errors = 0;
    int tests_run = 0;
    assign cfg_pins = {3'h0, ext_sel, sh_pd, ctl_pd, heat, spread};
    always #2 sys_clk = !sys_clk;

    auxsq_top #(.HALF_MS_CYCLES(HALF)) u_auxsq_top (
        .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .enable_pin(enable_pin), .aux_output_one_o(one_o),
        .aux_output_one_oe(one_oe), .external_clock_input_pin_i(two_pin),
        .aux_output_two_o(two_o), .aux_output_two_oe(two_oe),
        .external_clock(ext_clk), .external_clock_selected(ext_sel),
        .shared_pin_pulldown(sh_pd), .control_pin_pulldown(ctl_pd),
        .die_heat_warning_threshold(heat), .clock_spreading_on(spread));
    auxsq_pin_model u_auxsq_pin_model (
        .one_o(one_o), .one_oe(one_oe), .two_o(two_o), .two_oe(two_oe),
        .pd_on(sh_pd), .src_on(src_on), .src_lvl(src_lvl),
        .one_pin(one_pin), .two_pin(two_pin));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Extra cycle at the end lets registered outputs follow
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, string w);
        @(negedge sys_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        @(negedge sys_clk);
        check(w, reg_rd_data, e);
    endtask : rd
    // Edges to the pin level; both outputs timed on one enable edge
    task automatic lat(input logic lvl, output int n1, output int n2);
        n1 = 0;
        n2 = 0;
        @(negedge sys_clk);
        enable_pin = lvl;
        for (int i = 1; i <= 400 && (n1 == 0 || n2 == 0); i++) begin
            @(negedge sys_clk);
            if (n1 == 0 && one_pin === lvl) n1 = i;
            if (n2 == 0 && two_pin === lvl) n2 = i;
        end
        if (n1 == 0 || n2 == 0) begin
            n_errors++;
            give_verdict();
        end
    endtask : lat

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd(8'h10, 8'h00, "delays one reset");
        rd(8'h13, 8'h00, "config reset");
        wr(8'h12, 8'hff);
        rd(8'h12, 8'h77, "control");
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00, "unmapped");
        wr(8'h11, 8'ha5);
        rd(8'h11, 8'ha5, "delays two");
        wr(8'h13, 8'h60);
        rd(8'h13, 8'h60, "config");
    endtask : t_regs
    task automatic t_config;
        for (int b = 0; b < 5; b++) begin
            wr(8'h13, 8'h01 << b);
            check("config", cfg_pins, 8'h01 << b);
        end
    endtask : t_config
    task automatic t_static;
        logic [7:0] cv [4] = '{8'h11, 8'h00, 8'h55, 8'h44};
        logic [3:0] ev [4] = '{4'hf, 4'h5, 4'ha, 4'h5};
        wr(8'h13, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h12, cv[k]);
            enable_pin = !enable_pin;
            repeat (4) @(negedge sys_clk);
            check("out one", {one_pin, one_oe}, ev[k][3:2]);
            check("out two", {two_pin, two_oe}, ev[k][1:0]);
        end
        enable_pin = 1'b0;
    endtask : t_static
    task automatic t_delays;
        int b1r, b2r, b1f, b2f, n1, n2, w, f;
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h33);
        lat(1'b1, b1r, b2r);
        lat(1'b0, b1f, b2f);
        check("immediate rise", {b1r[7:0], b2r[7:0]}, 16'h0202);
        check("immediate fall", {b1f[7:0], b2f[7:0]}, 16'h0202);
        wr(8'h10, 8'h2f);
        wr(8'h11, 8'hf1);
        // Half-ms steps per code unit: rise range wide first, then fall
        for (int k = 0; k < 2; k++) begin
            w = 2 - k;
            f = 1 + k;
            wr(8'h13, k ? 8'h20 : 8'h40);
            lat(1'b1, n1, n2);
            check("one rise", 16'(n1 - b1r), 16'(15 * w * HALF));
            check("two rise", 16'(n2 - b2r), 16'(1 * w * HALF));
            lat(1'b0, n1, n2);
            check("one fall", 16'(n1 - b1f), 16'(2 * f * HALF));
            check("two fall", 16'(n2 - b2f), 16'(15 * f * HALF));
        end
        // Gated with level low: sequence alone must not raise the pins
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h22);
        enable_pin = 1'b1;
        repeat (5) @(negedge sys_clk);
        check("gated low", {one_pin, two_pin}, 2'b00);
        enable_pin = 1'b0;
    endtask : t_delays
    task automatic t_clock;
        wr(8'h12, 8'h11);
        wr(8'h13, 8'h10);
        src_on = 1'b1;
        for (int k = 0; k < 4; k++) begin
            src_lvl = !src_lvl;
            repeat (2) @(negedge sys_clk);
            check("clock path", {ext_clk, two_oe}, {src_lvl, 1'b0});
        end
        src_on = 1'b0;
        wr(8'h13, 8'h18);
        check("shared pull-down", two_pin, 1'b0);
        wr(8'h13, 8'h00);
        check("output mode", {ext_clk, two_pin, two_oe}, 3'b011);
    endtask : t_clock

    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        t_regs();
        t_config();
        t_static();
        t_delays();
        t_clock();
        give_verdict();
    end
endmodule : auxsq_bench
